//--- inc/hrl_pkg.sv
// Package for the hex record loader: constants, states and a carrier struct.
// Assumes a single clock domain; characters arrive as 8-bit ASCII codes.
`default_nettype none
package hrl_pkg;
   // ==========================================
   // Record layout
   localparam logic [7:0] CHAR_COLON = 8'h3A;
   localparam logic [7:0] TYPE_DATA = 8'h00;
   localparam logic [7:0] TYPE_SEG = 8'h02;
   localparam logic [7:0] TYPE_START = 8'h03;
   localparam logic [7:0] SEG_COUNT = 8'h02;
   localparam logic [7:0] START_COUNT = 8'h04;
   localparam logic [7:0] MAX_DATA = 8'h10;
   localparam int ADDR_W = 20;
   localparam int SEG_SHIFT = 4;
   localparam int FIFO_DEPTH = 8;
   // ==========================================
   // Reset values
   localparam logic [15:0] SEG_RESET = 16'h0000;
   localparam logic [15:0] START_RESET = 16'h0000;

   typedef enum logic [2:0] {
      HRL_IDLE = 3'b000,
      HRL_COUNT = 3'b001,
      HRL_OFFSET = 3'b010,
      HRL_TYPE = 3'b011,
      HRL_DATA = 3'b100,
      HRL_SUM = 3'b101
   } hrl_state_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
   } hrl_wr_s;
endpackage : hrl_pkg
`default_nettype wire

//--- hw/hrl_fifo.sv
// Valid/ready FIFO buffering data-record bytes ahead of memory writes.
// Assumes both sides on the same clock; pop and push may share a cycle.
`timescale 1ns/1ps
`default_nettype none
module hrl_fifo #(
   parameter int WIDTH = 28,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [PW:0] cnt_ff, nxt_cnt;
   logic push, pop;

   always_comb begin
      push = in_valid_i && (cnt_ff != DEPTH[PW:0]);
      pop = out_valid_o && out_ready_i;
      nxt_wr = push ? ((wr_ff == PW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1) : wr_ff;
      nxt_rd = pop ? ((rd_ff == PW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1) : rd_ff;
      nxt_cnt = cnt_ff + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
   end

   assign in_ready_o = (cnt_ff != DEPTH[PW:0]);
   assign out_valid_o = (cnt_ff != '0);
   assign out_data_o = mem_ff[rd_ff];

   // Storage has no reset; only the pointers and the count need a defined value
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end
endmodule : hrl_fifo
`default_nettype wire

//--- hw/hrl_loader.sv
// Hex record decoder: parses ASCII characters into memory writes and start values.
// Assumes characters arrive with a valid/ready handshake on sys_clk_i from local logic.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Colon always starts a fresh record
// - Columns 2-3 give byte count, high first
// - Columns 4-7 offset plus segment base
// - Type 00 marks a data record
// - Up to 16 data bytes, high nibble first
// - Bytes go to consecutive ascending addresses
// - Checksum is negated modulo-256 byte sum
// - Type 03 with count 04, offset 0000 is start record
// - Columns 10-13 give code segment start
// - Columns 14-17 give instruction pointer start
// - Start record checksum checked the same way
// - Type 02 count 02 sets segment base
// - Segment base zero until first segment record
module hrl_loader #(
   parameter int DEPTH = hrl_pkg::FIFO_DEPTH
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic char_valid_i,
   input wire logic [7:0] char_i,
   output logic char_ready_o,
   output logic wr_valid_o,
   input wire logic wr_ready_i,
   output hrl_pkg::hrl_wr_s wr_o,
   output logic [15:0] code_segment_start_o,
   output logic [15:0] instruction_pointer_start_value_o,
   output logic [15:0] segment_base_o,
   output logic record_done_o,
   output logic error_o
);
   // ==========================================
   // Parser state
   hrl_pkg::hrl_state_e st_ff, nxt_st;
   logic [7:0] count_ff, nxt_count;
   logic [15:0] offset_ff, nxt_offset;
   logic [7:0] type_ff, nxt_type;
   logic [7:0] sum_ff, nxt_sum;
   logic [7:0] idx_ff, nxt_idx;
   logic [31:0] payload_ff, nxt_payload;
   logic hi_ff, nxt_hi;
   logic [3:0] nib_ff, nxt_nib;
   logic [15:0] seg_ff, nxt_seg;
   logic [15:0] cs_ff, nxt_cs;
   logic [15:0] ip_ff, nxt_ip;
   logic done_ff, nxt_done;
   logic err_ff, nxt_err;
   logic [7:0] fld_ff, nxt_fld;

   // Data bytes are held back until the checksum is known, since a bad
   // record must not write; the FIFO only receives committed bytes.
   logic [7:0] dbuf_ff [16];
   logic [7:0] dcnt_ff, nxt_dcnt;
   logic [3:0] drd_ff, nxt_drd;
   logic [19:0] daddr_ff, nxt_daddr;
   logic dbuf_wr;

   logic take, is_hex, byte_done;
   logic [3:0] hex_val;
   logic [7:0] byte_val;
   logic fifo_in_ready, push;
   hrl_pkg::hrl_wr_s push_data;

   always_comb begin
      is_hex = 1'b1;
      hex_val = 4'h0;
      if (char_i >= 8'h30 && char_i <= 8'h39) begin
         hex_val = 4'(char_i - 8'h30);
      end else if (char_i >= 8'h41 && char_i <= 8'h46) begin
         hex_val = 4'(char_i - 8'h37);
      end else if (char_i >= 8'h61 && char_i <= 8'h66) begin
         hex_val = 4'(char_i - 8'h57);
      end else begin
         is_hex = 1'b0;
      end
   end

   // Input stalls while committed bytes are still draining
   assign char_ready_o = (dcnt_ff == 8'h00);
   assign take = char_valid_i && char_ready_o;
   assign byte_val = {nib_ff, hex_val};
   assign byte_done = take && is_hex && !hi_ff && st_ff != hrl_pkg::HRL_IDLE;

   always_comb begin
      nxt_st = st_ff;
      nxt_count = count_ff;
      nxt_offset = offset_ff;
      nxt_type = type_ff;
      nxt_sum = sum_ff;
      nxt_idx = idx_ff;
      nxt_payload = payload_ff;
      nxt_hi = hi_ff;
      nxt_nib = nib_ff;
      nxt_seg = seg_ff;
      nxt_cs = cs_ff;
      nxt_ip = ip_ff;
      nxt_done = 1'b0;
      nxt_err = 1'b0;
      nxt_fld = fld_ff;
      nxt_dcnt = dcnt_ff;
      nxt_daddr = daddr_ff;
      dbuf_wr = 1'b0;
      if (take && char_i == hrl_pkg::CHAR_COLON) begin
         nxt_st = hrl_pkg::HRL_COUNT;
         nxt_sum = 8'h00;
         nxt_hi = 1'b1;
         nxt_idx = 8'h00;
         nxt_fld = 8'h00;
      end else if (take && st_ff != hrl_pkg::HRL_IDLE && !is_hex) begin
         nxt_st = hrl_pkg::HRL_IDLE;
         nxt_err = 1'b1;
      end else if (take && hi_ff && st_ff != hrl_pkg::HRL_IDLE) begin
         nxt_nib = hex_val;
         nxt_hi = 1'b0;
      end else if (byte_done) begin
         nxt_hi = 1'b1;
         nxt_sum = sum_ff + byte_val;
         case (st_ff)
            hrl_pkg::HRL_COUNT: begin
               nxt_count = byte_val;
               nxt_st = hrl_pkg::HRL_OFFSET;
               nxt_fld = 8'h00;
            end
            hrl_pkg::HRL_OFFSET: begin
               nxt_offset = {offset_ff[7:0], byte_val};
               nxt_fld = fld_ff + 8'h01;
               if (fld_ff == 8'h01) begin
                  nxt_st = hrl_pkg::HRL_TYPE;
               end
            end
            hrl_pkg::HRL_TYPE: begin
               nxt_type = byte_val;
               nxt_idx = 8'h00;
               nxt_st = (count_ff == 8'h00) ? hrl_pkg::HRL_SUM : hrl_pkg::HRL_DATA;
            end
            hrl_pkg::HRL_DATA: begin
               if (type_ff == hrl_pkg::TYPE_DATA && idx_ff < hrl_pkg::MAX_DATA) begin
                  dbuf_wr = 1'b1;
               end
               nxt_payload = {payload_ff[23:0], byte_val};
               nxt_idx = idx_ff + 8'h01;
               if (idx_ff + 8'h01 == count_ff) begin
                  nxt_st = hrl_pkg::HRL_SUM;
               end
            end
            hrl_pkg::HRL_SUM: begin
               nxt_st = hrl_pkg::HRL_IDLE;
               nxt_done = 1'b1;
               if (sum_ff + byte_val != 8'h00) begin
                  nxt_err = 1'b1;
               end else if (type_ff == hrl_pkg::TYPE_DATA && count_ff <= hrl_pkg::MAX_DATA) begin
                  nxt_dcnt = count_ff;
                  nxt_daddr = 20'({seg_ff, 4'h0}) + 20'(offset_ff);
               end else if (type_ff == hrl_pkg::TYPE_SEG && count_ff == hrl_pkg::SEG_COUNT) begin
                  nxt_seg = payload_ff[15:0];
               end else if (type_ff == hrl_pkg::TYPE_START
                            && count_ff == hrl_pkg::START_COUNT
                            && offset_ff == 16'h0000) begin
                  nxt_cs = payload_ff[31:16];
                  nxt_ip = payload_ff[15:0];
               end else begin
                  nxt_err = 1'b1;
               end
            end
            default: begin
               nxt_st = hrl_pkg::HRL_IDLE;
            end
         endcase
      end
      if (push) begin
         nxt_dcnt = dcnt_ff - 8'h01;
         nxt_daddr = daddr_ff + 20'h00001;
      end
   end

   assign nxt_drd = push ? drd_ff + 4'h1 : (nxt_dcnt == 8'h00 ? 4'h0 : drd_ff);
   assign push = (dcnt_ff != 8'h00) && fifo_in_ready;
   assign push_data.addr = daddr_ff;
   assign push_data.data = dbuf_ff[drd_ff];

   always_ff @(posedge sys_clk_i) begin
      if (dbuf_wr) begin
         dbuf_ff[idx_ff[3:0]] <= byte_val;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_ff <= hrl_pkg::HRL_IDLE;
         count_ff <= 8'h00;
         offset_ff <= 16'h0000;
         type_ff <= 8'h00;
         sum_ff <= 8'h00;
         idx_ff <= 8'h00;
         payload_ff <= 32'h00000000;
         hi_ff <= 1'b1;
         nib_ff <= 4'h0;
         seg_ff <= hrl_pkg::SEG_RESET;
         cs_ff <= hrl_pkg::START_RESET;
         ip_ff <= hrl_pkg::START_RESET;
         done_ff <= 1'b0;
         err_ff <= 1'b0;
         fld_ff <= 8'h00;
         dcnt_ff <= 8'h00;
         drd_ff <= 4'h0;
         daddr_ff <= 20'h00000;
      end else begin
         st_ff <= nxt_st;
         count_ff <= nxt_count;
         offset_ff <= nxt_offset;
         type_ff <= nxt_type;
         sum_ff <= nxt_sum;
         idx_ff <= nxt_idx;
         payload_ff <= nxt_payload;
         hi_ff <= nxt_hi;
         nib_ff <= nxt_nib;
         seg_ff <= nxt_seg;
         cs_ff <= nxt_cs;
         ip_ff <= nxt_ip;
         done_ff <= nxt_done;
         err_ff <= nxt_err;
         fld_ff <= nxt_fld;
         dcnt_ff <= nxt_dcnt;
         drd_ff <= nxt_drd;
         daddr_ff <= nxt_daddr;
      end
   end

   // ==========================================
   // Output buffer
   hrl_fifo #(
      .WIDTH($bits(hrl_pkg::hrl_wr_s)),
      .DEPTH(DEPTH)
   ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(dcnt_ff != 8'h00),
      .in_ready_o(fifo_in_ready),
      .in_data_i(push_data),
      .out_valid_o(wr_valid_o),
      .out_ready_i(wr_ready_i),
      .out_data_o(wr_o)
   );

   assign code_segment_start_o = cs_ff;
   assign instruction_pointer_start_value_o = ip_ff;
   assign segment_base_o = seg_ff;
   assign record_done_o = done_ff;
   assign error_o = err_ff;
endmodule : hrl_loader
`default_nettype wire

//--- testbench/hrl_loader_sva.sv
// Checker for the hex record loader ports.
// Assumes one clock and the active-low reset of the loader.
`timescale 1ns/1ps
`default_nettype none
module hrl_loader_sva (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic char_ready_o,
   input wire logic wr_valid_o,
   input wire logic wr_ready_i,
   input wire hrl_pkg::hrl_wr_s wr_o,
   input wire logic [15:0] code_segment_start_o,
   input wire logic [15:0] instruction_pointer_start_value_o,
   input wire logic [15:0] segment_base_o,
   input wire logic record_done_o,
   input wire logic error_o
);
   // ======
   // Properties
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   chk_wr_hold: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_o))
      else $error("write changed while stalled");
   chk_err_pulse: assert property (error_o |=> !error_o)
      else $error("error longer than one cycle");
   chk_done_pulse: assert property (record_done_o |=> !record_done_o)
      else $error("done longer than one cycle");
   chk_err_keeps: assert property (error_o |-> $stable(segment_base_o) &&
      $stable(code_segment_start_o) && $stable(instruction_pointer_start_value_o))
      else $error("bad record changed a value");
   chk_err_nodrain: assert property (error_o |-> char_ready_o)
      else $error("bad record drains bytes");
   chk_seg_done: assert property ($changed(segment_base_o) |->
      ($past(record_done_o) || record_done_o) or ##1 record_done_o)
      else $error("segment base changed outside a record end");
   chk_start_done: assert property ($changed({code_segment_start_o,
      instruction_pointer_start_value_o}) |->
      ($past(record_done_o) || record_done_o) or ##1 record_done_o)
      else $error("start values changed outside a record end");
   chk_drain_wr: assert property ($fell(char_ready_o) |-> ##[1:3] wr_valid_o)
      else $error("drain without writes");
   cover property (error_o);
   cover property (wr_valid_o && !wr_ready_i ##1 wr_valid_o && wr_ready_i);
   cover property ($changed(segment_base_o));
endmodule : hrl_loader_sva
bind hrl_loader hrl_loader_sva chk (.*);
`default_nettype wire

//--- testbench/hrl_host.sv
// Host model sending ASCII hex records one character at a time.
// Assumes the loader's ready is settled at each falling edge.
`timescale 1ns/1ps
`default_nettype none
module hrl_host (
   input wire logic sys_clk_i,
   input wire logic char_ready_i,
   output var logic char_valid_o,
   output var logic [7:0] char_o,
   output var logic stuck_o
);
   initial begin
      char_valid_o = 1'b0;
      char_o = 8'h00;
      stuck_o = 1'b0;
   end
   function automatic logic [7:0] hex(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
   endfunction : hex
   // Idle line shows the inverse so a stale character never looks valid
   task automatic send_char(input logic [7:0] c);
      int n;
      n = 0;
      @(posedge sys_clk_i) #1;
      char_valid_o = 1'b1;
      char_o = c;
      do begin
         @(negedge sys_clk_i);
         n++;
      end while (!char_ready_i && n < 300);
      if (n >= 300) stuck_o = 1'b1;
      @(posedge sys_clk_i) #1;
      char_valid_o = 1'b0;
      char_o = ~c;
   endtask : send_char
   task automatic send_rec(input logic [7:0] b[$], input logic [7:0] bias);
      logic [7:0] s;
      s = 8'h00;
      send_char(8'h3A);
      foreach (b[i]) s += b[i];
      b.push_back(8'h00 - s + bias);
      foreach (b[i]) begin
         send_char(hex(b[i][7:4]));
         send_char(hex(b[i][3:0]));
      end
   endtask : send_rec
endmodule : hrl_host
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the hex record loader.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic sys_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic wr_ready_i = 1'b0;
   logic hold = 1'b0;
   logic char_valid, char_ready, wr_valid, done, err, stuck;
   logic [7:0] char_c;
   logic [15:0] cs, ip, seg, v;
   logic [15:0] base = 16'h0000;
   hrl_pkg::hrl_wr_s wr;
   hrl_pkg::hrl_wr_s exp_q[$];
   logic [7:0] r[$];
   int errors = 0;
   int n_compared = 0;
   always #50 sys_clk_i = ~sys_clk_i;
   // Random stalls keep the buffer both filling and draining
   always @(posedge sys_clk_i) wr_ready_i <= #1 !hold && ($urandom % 4 != 0);
   hrl_host host (.sys_clk_i(sys_clk_i), .char_ready_i(char_ready),
      .char_valid_o(char_valid), .char_o(char_c), .stuck_o(stuck));
   hrl_loader dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .char_valid_i(char_valid),
      .char_i(char_c), .char_ready_o(char_ready), .wr_valid_o(wr_valid),
      .wr_ready_i(wr_ready_i), .wr_o(wr), .code_segment_start_o(cs),
      .instruction_pointer_start_value_o(ip), .segment_base_o(seg),
      .record_done_o(done), .error_o(err));
   // ======
   // Checking
   task automatic chk(input string what, input logic [27:0] e, input logic [27:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask : chk
   task automatic wrap_up();
      if (errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up
   always @(posedge stuck) begin
      errors++;
      wrap_up();
   end
   // Falling edge: both sides have settled for the rising edge that takes the write
   always @(negedge sys_clk_i) begin
      if (wr_valid === 1'b1 && wr_ready_i === 1'b1) begin
         if (exp_q.size() == 0) chk("stray write", 28'hx, wr);
         else chk("write", exp_q.pop_front(), wr);
      end
   end
   // ======
   // Stimulus
   task automatic rec(input logic [7:0] bias, input logic bad);
      int n;
      host.send_rec(r, bias);
      n = 0;
      // The done pulse already stands when the last character is released
      while (done !== 1'b1 && n < 8) begin
         @(posedge sys_clk_i) #1;
         n++;
      end
      chk("done", 28'h1, {27'h0, done});
      if (done !== 1'b1) wrap_up();
      chk("error", {27'h0, bad}, {27'h0, err});
      @(posedge sys_clk_i) #2;
   endtask : rec
   task automatic data_rec(input logic [15:0] off, input int cnt, input logic [7:0] bias);
      r = {8'(cnt), off[15:8], off[7:0], 8'h00};
      for (int i = 0; i < cnt; i++) begin
         r.push_back(8'($urandom));
         if (bias == 8'h00) exp_q.push_back({{base, 4'h0} + 20'(off) + 20'(i), r[i + 4]});
      end
      rec(bias, bias != 8'h00);
   endtask : data_rec
   initial begin
      void'($urandom(32'h1957));
      repeat (12) @(posedge sys_clk_i);
      #1 reset_n_i = 1'b1;
      data_rec(16'h0010, 3, 8'h00);
      r = {8'h02, 8'h00, 8'h00, 8'h02, 8'h12, 8'h34};
      rec(8'h00, 1'b0);
      base = 16'h1234;
      chk("segment", 28'(base), 28'(seg));
      hold = 1'b1;
      data_rec(16'hFFF8, 16, 8'h00);
      repeat (20) @(posedge sys_clk_i);
      chk("stall", 28'h0, 28'(char_ready));
      #1 hold = 1'b0;
      data_rec(16'h0000, 2, 8'h01);
      r = {8'h00, 8'h00, 8'h00, 8'h01};
      rec(8'h00, 1'b1);
      host.send_char(8'h3A);
      host.send_char(8'h47);
      chk("bad char", 28'h1, {27'h0, err});
      host.send_char(8'h3A);
      host.send_char(8'h31);
      v = 16'($urandom);
      r = {8'h04, 8'h00, 8'h00, 8'h03, v[15:8], v[7:0], ~v[15:8], ~v[7:0]};
      rec(8'h00, 1'b0);
      chk("code segment", 28'(v), 28'(cs));
      chk("pointer", {12'h000, ~v}, 28'(ip));
      r[4] = ~r[4];
      rec(8'h01, 1'b1);
      chk("kept segment", 28'(v), 28'(cs));
      for (int k = 0; k < 500 && exp_q.size() != 0; k++) @(posedge sys_clk_i);
      chk("pending", 28'h0, 28'(exp_q.size()));
      wrap_up();
   end
endmodule : tb
`default_nettype wire
